// ---- logic/crx_accept_filter.sv ----
// identifier acceptance test against code and mask
`timescale 1ns/1ps
module crx_accept_filter (
    input wire logic [7:0] idHigh,
    input wire logic [7:0] codeBits,
    input wire logic [7:0] maskBits,
    output logic accept
);
    // mask one marks a don't-care position; id bits 2..0 never reach here
    always_comb begin
        accept = &((~(idHigh ^ codeBits)) | maskBits);
    end
endmodule : crx_accept_filter

// ---- logic/crx_rx_path.sv ----
// receive message queue, receive window and acceptance filter registers
`timescale 1ns/1ps
// Function
// - window at addresses 20..29 shows identifier, RTR and length as transmit layout
// - queue holds 64 bytes; message count depends on message lengths
// - message not fitting remaining space raises overrun
// - on overrun, partly written bytes are dropped, earlier messages kept
// - overrun reported only when the frame becomes valid
// - only messages passing the acceptance filter are stored
// - filter code register, 8 bits at address 4
// - filter mask register, 8 bits at address 5
// - filter registers accessible only while reset request bit is set
// - accept when id bits 10..3 match code, or mask bit is one
// - mask zero makes a bit relevant, mask one makes it don't-care
// - accepted message stores descriptor bytes then data bytes in order
// - full flag sets after complete correct reception
// - receive event flag sets on reception when enabled
// - receive event clears on read; sets again after release if messages remain
// - overrun event and overrun status set in the same cycle
module crx_rx_path #(
    parameter int FIFO_DEPTH = crx_pkg::FIFO_BYTES
) (
    input wire logic clock,
    input wire logic rst_n,
    input crx_pkg::crx_host_t host,
    output logic [7:0] hostRdata,
    input crx_pkg::crx_bsp_t bsp,
    input wire logic resetRequestBit,
    input wire logic receiveIntEnable,
    input wire logic overrunIntEnable,
    input wire logic releaseReceiveCmd,
    input wire logic clearOverrunCmd,
    output logic receiveFullFlag,
    output logic overrunStatusFlag,
    output logic receiveEventFlag,
    output logic overrunEventFlag
);
    // six-bit pointers serve exactly one depth, refused at elaboration
    if (FIFO_DEPTH != crx_pkg::FIFO_BYTES) begin : g_depthCheck
        $error("queue depth must be 64, pointers are six bits");
    end

    // bytes a message occupies: descriptor plus data, remote frames carry none
    function automatic logic [6:0] msgBytes(input logic [7:0] desc2);
        logic [3:0] dlc;
        dlc = desc2[3:0];
        if (desc2[crx_pkg::RTR_BIT]) begin
            msgBytes = crx_pkg::DESCRIPTOR_BYTES;
        end else if (dlc > crx_pkg::MAX_DATA_BYTES) begin
            msgBytes = crx_pkg::DESCRIPTOR_BYTES + {3'h0, crx_pkg::MAX_DATA_BYTES};
        end else begin
            msgBytes = crx_pkg::DESCRIPTOR_BYTES + {3'h0, dlc};
        end
    endfunction : msgBytes

    logic [7:0] queueMem [FIFO_DEPTH];
    logic [5:0] readStart_reg, readStart_next;
    logic [5:0] writePtr_reg, writePtr_next;
    logic [5:0] writeStart_reg, writeStart_next;
    logic [6:0] usedBytes_reg, usedBytes_next;
    logic [6:0] pendBytes_reg, pendBytes_next;
    logic [5:0] msgCount_reg, msgCount_next;
    logic overrunPend_reg, overrunPend_next;
    crx_pkg::crx_state_t state_reg, state_next;
    logic [7:0] filterCode_reg, filterCode_next;
    logic [7:0] filterMask_reg, filterMask_next;
    logic [7:0] rdata_reg, rdata_next;
    logic fullFlag_reg, fullFlag_next;
    logic ovStatus_reg, ovStatus_next;
    logic rxEvent_reg, rxEvent_next;
    logic ovEvent_reg, ovEvent_next;
    logic memWe;
    logic idAccept;
    logic commit;
    logic releaseOk;
    logic ovSet;
    logic [5:0] winIdx;
    logic [6:0] oldestLen;

    crx_accept_filter u_filter (
        .idHigh(bsp.data),
        .codeBits(filterCode_reg),
        .maskBits(filterMask_reg),
        .accept(idAccept)
    );

    // oldest message length from its second descriptor byte
    assign oldestLen = msgBytes(queueMem[readStart_reg + 6'h01]);

    // reception state and write pointers
    always_comb begin
        state_next = state_reg;
        writePtr_next = writePtr_reg;
        writeStart_next = writeStart_reg;
        pendBytes_next = pendBytes_reg;
        overrunPend_next = overrunPend_reg;
        memWe = 1'b0;
        commit = 1'b0;
        ovSet = 1'b0;
        unique case (state_reg)
            crx_pkg::ST_IDLE: begin
            end
            crx_pkg::ST_STORE: begin
                if (bsp.byteValid) begin
                    // filter first: a rejected frame never claims space, so never overruns
                    if (pendBytes_reg == 7'h00 && !idAccept) begin
                        state_next = crx_pkg::ST_DROP;
                    end else if ((usedBytes_reg + pendBytes_reg) >= 7'(FIFO_DEPTH)) begin
                        overrunPend_next = 1'b1;
                        writePtr_next = writeStart_reg;
                        pendBytes_next = 7'h00;
                        state_next = crx_pkg::ST_DROP;
                    end else begin
                        memWe = 1'b1;
                        writePtr_next = writePtr_reg + 6'h01;
                        pendBytes_next = pendBytes_reg + 7'h01;
                    end
                end
                if (bsp.frameValid) begin
                    commit = 1'b1;
                    writeStart_next = writePtr_reg;
                    pendBytes_next = 7'h00;
                    state_next = crx_pkg::ST_IDLE;
                end
            end
            crx_pkg::ST_DROP: begin
                if (bsp.frameValid) begin
                    ovSet = overrunPend_reg;
                    state_next = crx_pkg::ST_IDLE;
                end
            end
            default: begin
                state_next = crx_pkg::ST_IDLE;
            end
        endcase
        // a new start or an error discards anything not yet committed
        if (bsp.start || bsp.frameError || resetRequestBit) begin
            writePtr_next = writeStart_reg;
            pendBytes_next = 7'h00;
            overrunPend_next = 1'b0;
            memWe = 1'b0;
            commit = 1'b0;
            ovSet = 1'b0;
            state_next = (bsp.start && !resetRequestBit) ? crx_pkg::ST_STORE : crx_pkg::ST_IDLE;
        end
    end

    // committed byte and message bookkeeping
    always_comb begin
        releaseOk = releaseReceiveCmd && (msgCount_reg != 6'h00);
        readStart_next = readStart_reg;
        usedBytes_next = usedBytes_reg;
        msgCount_next = msgCount_reg;
        if (releaseOk) begin
            readStart_next = readStart_reg + oldestLen[5:0];
            usedBytes_next = usedBytes_reg - oldestLen;
            msgCount_next = msgCount_reg - 6'h01;
        end
        if (commit) begin
            usedBytes_next = usedBytes_next + pendBytes_reg;
            msgCount_next = msgCount_next + 6'h01;
        end
        if (resetRequestBit) begin
            // entering reset mode empties the queue
            readStart_next = writeStart_reg;
            usedBytes_next = 7'h00;
            msgCount_next = 6'h00;
        end
    end

    // status and event flags; setting wins over clearing
    always_comb begin
        fullFlag_next = (msgCount_next != 6'h00);
        ovStatus_next = ovStatus_reg;
        if (clearOverrunCmd || resetRequestBit) begin
            ovStatus_next = 1'b0;
        end
        if (ovSet) begin
            ovStatus_next = 1'b1;
        end
        ovEvent_next = ovEvent_reg;
        rxEvent_next = rxEvent_reg;
        if (host.read && host.addr == crx_pkg::ADDR_INT) begin
            ovEvent_next = 1'b0;
            rxEvent_next = 1'b0;
        end
        if (ovSet && !ovStatus_reg && overrunIntEnable) begin
            ovEvent_next = 1'b1;
        end
        if (receiveIntEnable && (commit || (releaseOk && msgCount_reg != 6'h01))) begin
            rxEvent_next = 1'b1;
        end
    end

    // host access: filter registers only in reset mode, interrupt register and window in any mode
    always_comb begin
        filterCode_next = filterCode_reg;
        filterMask_next = filterMask_reg;
        rdata_next = rdata_reg;
        winIdx = readStart_reg + host.addr[5:0] - crx_pkg::ADDR_WINDOW_FIRST[5:0];
        if (host.write && resetRequestBit) begin
            if (host.addr == crx_pkg::ADDR_FILTER_CODE) begin
                filterCode_next = host.wdata;
            end
            if (host.addr == crx_pkg::ADDR_FILTER_MASK) begin
                filterMask_next = host.wdata;
            end
        end
        if (host.read) begin
            rdata_next = crx_pkg::READ_ZERO;
            if (host.addr == crx_pkg::ADDR_INT) begin
                rdata_next[crx_pkg::INT_RECEIVE_BIT] = rxEvent_reg;
                rdata_next[crx_pkg::INT_OVERRUN_BIT] = ovEvent_reg;
            end else if (host.addr == crx_pkg::ADDR_FILTER_CODE) begin
                rdata_next = resetRequestBit ? filterCode_reg : crx_pkg::FILTER_LOCKED_READ;
            end else if (host.addr == crx_pkg::ADDR_FILTER_MASK) begin
                rdata_next = resetRequestBit ? filterMask_reg : crx_pkg::FILTER_LOCKED_READ;
            end else if (host.addr >= crx_pkg::ADDR_WINDOW_FIRST &&
                         host.addr <= crx_pkg::ADDR_WINDOW_LAST) begin
                rdata_next = queueMem[winIdx];
            end
        end
    end

    // queue storage has no reset; window reads are not limited to committed bytes
    always_ff @(posedge clock) begin
        if (memWe) begin
            queueMem[writePtr_reg] <= bsp.data;
        end
    end

    // register all control state
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= crx_pkg::ST_IDLE;
            readStart_reg <= 6'h00;
            writePtr_reg <= 6'h00;
            writeStart_reg <= 6'h00;
            usedBytes_reg <= 7'h00;
            pendBytes_reg <= 7'h00;
            msgCount_reg <= 6'h00;
            overrunPend_reg <= 1'b0;
            filterCode_reg <= crx_pkg::FILTER_CODE_RESET;
            filterMask_reg <= crx_pkg::FILTER_MASK_RESET;
            rdata_reg <= crx_pkg::READ_ZERO;
            fullFlag_reg <= 1'b0;
            ovStatus_reg <= 1'b0;
            rxEvent_reg <= 1'b0;
            ovEvent_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            readStart_reg <= readStart_next;
            writePtr_reg <= writePtr_next;
            writeStart_reg <= writeStart_next;
            usedBytes_reg <= usedBytes_next;
            pendBytes_reg <= pendBytes_next;
            msgCount_reg <= msgCount_next;
            overrunPend_reg <= overrunPend_next;
            filterCode_reg <= filterCode_next;
            filterMask_reg <= filterMask_next;
            rdata_reg <= rdata_next;
            fullFlag_reg <= fullFlag_next;
            ovStatus_reg <= ovStatus_next;
            rxEvent_reg <= rxEvent_next;
            ovEvent_reg <= ovEvent_next;
        end
    end

    assign hostRdata = rdata_reg;
    assign receiveFullFlag = fullFlag_reg;
    assign overrunStatusFlag = ovStatus_reg;
    assign receiveEventFlag = rxEvent_reg;
    assign overrunEventFlag = ovEvent_reg;
endmodule : crx_rx_path

// ---- shared/crx_pkg.sv ----
// constants and carrier types for the receive path and acceptance filter
package crx_pkg;
    // host addresses
    localparam logic [7:0] ADDR_INT = 8'h03;
    localparam logic [7:0] ADDR_FILTER_CODE = 8'h04;
    localparam logic [7:0] ADDR_FILTER_MASK = 8'h05;
    localparam logic [7:0] ADDR_WINDOW_FIRST = 8'h14;
    localparam logic [7:0] ADDR_WINDOW_LAST = 8'h1D;
    // interrupt register field positions
    localparam int INT_RECEIVE_BIT = 0;
    localparam int INT_OVERRUN_BIT = 3;
    // reset values and fixed read values
    localparam logic [7:0] FILTER_CODE_RESET = 8'h00;
    localparam logic [7:0] FILTER_MASK_RESET = 8'h00;
    localparam logic [7:0] FILTER_LOCKED_READ = 8'hFF;
    localparam logic [7:0] READ_ZERO = 8'h00;
    // message layout
    localparam int FIFO_BYTES = 64;
    localparam logic [6:0] DESCRIPTOR_BYTES = 7'h02;
    localparam logic [3:0] MAX_DATA_BYTES = 4'h8;
    localparam int RTR_BIT = 4;

    // byte stream from the bit stream processor
    typedef struct packed {
        logic start;       // frame start pulse
        logic byteValid;   // one received byte, identifier byte first
        logic [7:0] data;
        logic frameValid;  // frame error-free to next-to-last end-of-frame bit
        logic frameError;  // frame aborted
    } crx_bsp_t;

    // host register request
    typedef struct packed {
        logic read;
        logic write;
        logic [7:0] addr;
        logic [7:0] wdata;
    } crx_host_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_STORE = 2'b01,
        ST_DROP = 2'b10
    } crx_state_t;
endpackage : crx_pkg

// ---- sim/can_rx_fifo_acceptance_filter_tb_top.sv ----
// self-checking bench for the receive path and acceptance filter
`timescale 1ns/1ps
module can_rx_fifo_acceptance_filter_tb_top;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    crx_pkg::crx_host_t host = '0;
    logic [7:0] hostRdata;
    crx_pkg::crx_bsp_t bsp;
    logic resetRequestBit = 1'b1;
    logic receiveIntEnable = 1'b1;
    logic overrunIntEnable = 1'b1;
    logic releaseReceiveCmd = 1'b0;
    logic clearOverrunCmd = 1'b0;
    logic receiveFullFlag, overrunStatusFlag, receiveEventFlag, overrunEventFlag;
    wire logic [3:0] flags = {receiveFullFlag, overrunStatusFlag, receiveEventFlag,
        overrunEventFlag};
    int miscompares = 0;
    int total_checks = 0;
    crx_rx_path dut (.clock, .rst_n, .host, .hostRdata, .bsp, .resetRequestBit,
        .receiveIntEnable, .overrunIntEnable, .releaseReceiveCmd, .clearOverrunCmd,
        .receiveFullFlag, .overrunStatusFlag, .receiveEventFlag, .overrunEventFlag);
    crx_bsp_model m (.clock, .bsp);
    initial forever #2 clock = ~clock;
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t read %h expected %h", $time, got, exp);
        end
    endtask : chk8
    task automatic chkf(input logic [3:0] exp);
        total_checks++;
        if (flags !== exp) begin
            miscompares++;
            $display("[FAIL] %0t flags %b expected %b", $time, flags, exp);
        end
    endtask : chkf
    // strobes are raised and dropped on falling edges, one cycle wide
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock) host = '{read: 1'b0, write: 1'b1, addr: a, wdata: d};
        @(negedge clock) host.write = 1'b0;
    endtask : wr
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clock) host = '{read: 1'b1, write: 1'b0, addr: a, wdata: 8'h00};
        @(negedge clock) host.read = 1'b0;
        @(negedge clock) chk8(hostRdata, exp);
    endtask : rdchk
    task automatic rel;
        @(negedge clock) releaseReceiveCmd = 1'b1;
        @(negedge clock) releaseReceiveCmd = 1'b0;
    endtask : rel
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim
    // a hang well past the expected few hundred cycles ends the run
    initial begin
        #40000;
        miscompares++;
        end_sim();
    end
    initial begin
        repeat (2) @(negedge clock);
        rst_n = 1'b1;
        wr(8'h04, 8'hA5);
        wr(8'h05, 8'h0F);
        rdchk(8'h04, 8'hA5);
        rdchk(8'h05, 8'h0F);
        rdchk(8'h00, 8'h00);
        resetRequestBit = 1'b0;
        wr(8'h04, 8'h00);
        rdchk(8'h04, 8'hFF);
        resetRequestBit = 1'b1;
        rdchk(8'h04, 8'hA5);
        resetRequestBit = 1'b0;
        $display("test filter registers done");
        // masked low nibble differs from the code and still passes
        m.send_frame(8'hA3, 8'h43, 8'h11);
        chkf(4'hA);
        for (int k = 0; k < 5; k++) begin
            rdchk(8'h14 + k[7:0], k == 0 ? 8'hA3 : (k == 1 ? 8'h43 : 8'h0F + k[7:0]));
        end
        m.send_frame(8'h55, 8'h40, 8'h00);
        rdchk(8'h03, 8'h01);
        rel();
        chkf(4'h0);
        $display("test accept and reject done");
        // six ten-byte frames fill 60 bytes, the seventh cannot fit
        for (int i = 0; i < 7; i++) begin
            m.send_frame(8'hA0 | i[7:0], 8'h08, 8'(i * 16));
        end
        chkf(4'hF);
        rdchk(8'h14, 8'hA0);
        rdchk(8'h03, 8'h09);
        chkf(4'hC);
        @(negedge clock) clearOverrunCmd = 1'b1;
        @(negedge clock) clearOverrunCmd = 1'b0;
        chkf(4'h8);
        for (int i = 1; i < 6; i++) begin
            rel();
            chkf(4'hA);
            rdchk(8'h16, 8'(i * 16));
            rdchk(8'h03, 8'h01);
        end
        rel();
        chkf(4'h0);
        $display("test overrun and release done");
        // remote frame has no data, long length cut to eight, aborted frame leaves nothing
        m.send_frame(8'hA1, 8'h15, 8'h00);
        chkf(4'hA);
        m.send_aborted(8'hA2, 3);
        m.send_frame(8'hA3, 8'h0A, 8'h20);
        rdchk(8'h15, 8'h15);
        rdchk(8'h03, 8'h01);
        rel();
        chkf(4'hA);
        rdchk(8'h14, 8'hA3);
        rdchk(8'h1D, 8'h27);
        rel();
        chkf(4'h2);
        $display("test remote, long and aborted frames done");
        end_sim();
    end
endmodule : can_rx_fifo_acceptance_filter_tb_top

// ---- sim/crx_bsp_model.sv ----
// byte stream source standing in for the bit stream processor
`timescale 1ns/1ps
module crx_bsp_model (
    input wire logic clock,
    output crx_pkg::crx_bsp_t bsp
);
    initial bsp = '0;
    // sends exactly 2 + data count bytes; idle data is the inverse of the last byte
    task automatic send_frame(input logic [7:0] idHi, input logic [7:0] desc,
            input logic [7:0] base);
        int n;
        n = desc[crx_pkg::RTR_BIT] ? 0 : (desc[3:0] > 4'h8 ? 8 : int'(desc[3:0]));
        @(negedge clock) bsp.start = 1'b1;
        @(negedge clock) bsp.start = 1'b0;
        for (int k = 0; k < n + 2; k++) begin
            bsp.byteValid = 1'b1;
            bsp.data = k == 0 ? idHi : (k == 1 ? desc : base + 8'(k - 2));
            @(negedge clock);
        end
        bsp.byteValid = 1'b0;
        bsp.data = ~bsp.data;
        bsp.frameValid = 1'b1;
        @(negedge clock) bsp.frameValid = 1'b0;
    endtask : send_frame
    // frame cut by a bus error after some bytes; nothing of it may be committed
    task automatic send_aborted(input logic [7:0] idHi, input int count);
        @(negedge clock) bsp.start = 1'b1;
        @(negedge clock) bsp.start = 1'b0;
        for (int k = 0; k < count; k++) begin
            bsp.byteValid = 1'b1;
            bsp.data = idHi + 8'(k);
            @(negedge clock);
        end
        bsp.byteValid = 1'b0;
        bsp.data = ~bsp.data;
        bsp.frameError = 1'b1;
        @(negedge clock) bsp.frameError = 1'b0;
    endtask : send_aborted
endmodule : crx_bsp_model

// ---- sim/crx_rx_path_properties.sv ----
// concurrent checks on the receive path ports
`timescale 1ns/1ps
module crx_rx_path_checker #(
    parameter int FIFO_DEPTH = crx_pkg::FIFO_BYTES
) (
    input wire logic clock,
    input wire logic rst_n,
    input crx_pkg::crx_host_t host,
    input wire logic [7:0] hostRdata,
    input crx_pkg::crx_bsp_t bsp,
    input wire logic resetRequestBit,
    input wire logic receiveIntEnable,
    input wire logic overrunIntEnable,
    input wire logic releaseReceiveCmd,
    input wire logic clearOverrunCmd,
    input wire logic receiveFullFlag,
    input wire logic overrunStatusFlag,
    input wire logic receiveEventFlag,
    input wire logic overrunEventFlag
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // flag rises follow frame valid or their enable; read clear, locked read and hold checks
    AST_FULL_AFTER_VALID: assert property ($rose(receiveFullFlag) |-> $past(bsp.frameValid))
        else $error("full flag rose without frame valid");
    AST_EVT_NEEDS_EN: assert property ($rose(receiveEventFlag) |-> $past(receiveIntEnable))
        else $error("receive event rose while disabled");
    AST_OVR_AT_VALID: assert property ($rose(overrunStatusFlag) |-> $past(bsp.frameValid))
        else $error("overrun status rose without frame valid");
    AST_OVR_SAME_CYCLE: assert property ($rose(overrunStatusFlag)
        && $past(overrunIntEnable) |-> overrunEventFlag)
        else $error("overrun event not set with status");
    AST_OVR_EVT_ON_RISE: assert property ($rose(overrunEventFlag) |-> $rose(overrunStatusFlag))
        else $error("overrun event without status rise");
    AST_LOCKED_READ: assert property (host.read && host.addr == crx_pkg::ADDR_FILTER_CODE
        && !resetRequestBit |=> hostRdata == 8'hFF)
        else $error("filter code readable outside reset mode");
    AST_EVT_READ_CLEAR: assert property (host.read && host.addr == crx_pkg::ADDR_INT
        && !bsp.frameValid && !releaseReceiveCmd |=> !receiveEventFlag)
        else $error("receive event not cleared by read");
    AST_FULL_HOLDS: assert property (receiveFullFlag && !releaseReceiveCmd
        && !resetRequestBit |=> receiveFullFlag)
        else $error("full flag dropped without release");
    // main scenarios reached
    COV_FULL: cover property ($rose(receiveFullFlag));
    COV_OVR: cover property ($rose(overrunEventFlag));
    COV_REL: cover property (releaseReceiveCmd && receiveFullFlag ##1 receiveEventFlag);
endmodule : crx_rx_path_checker

bind crx_rx_path crx_rx_path_checker #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (.clock, .rst_n, .host,
    .hostRdata, .bsp, .resetRequestBit, .receiveIntEnable, .overrunIntEnable,
    .releaseReceiveCmd, .clearOverrunCmd, .receiveFullFlag, .overrunStatusFlag,
    .receiveEventFlag, .overrunEventFlag);
